/* common/tcc_map.svh */
// register map, field positions, opcodes and timing constants of the thermostat controller
// Operation
// RULE1: stored power-up select 1 gives thermostat start
// RULE2: supply low, line high, sixteen pulses escape
// RULE3: escape never alters stored power-up select
// RULE4: supply and line low ten seconds: off
// RULE5: temperature is signed eight-bit whole degrees
// RULE6: temperature readable only in communication mode
// RULE7: single select picks one-shot, communication only
// RULE8: start opcode repeats until stop opcode
// RULE9: one-shot start converts once then standby
// RULE10: done flag low converting, high after one-shot
// RULE11: counter read returns remaining gate count
// RULE12: load opcode copies slope into counter
// RULE13: output on above upper, off below lower
// RULE14: master writes trip points as signed degrees
// RULE15: polarity select one active-high, zero active-low
// RULE16: high flag sets above upper, master clears
// RULE17: low flag sets below lower, master clears
// RULE18: flags kept over power, both modes
// RULE19: flags and selects held in nonvolatile store
// RULE20: nonvolatile write busy up to ten ms
// RULE21: comparisons evaluated at each conversion end
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// ************************************************************
// opcodes
// ************************************************************
`define TCC_OP_RD_TEMP 8'hAA
`define TCC_OP_START 8'hEE
`define TCC_OP_STOP 8'h22
`define TCC_OP_WR_UPPER 8'h01
`define TCC_OP_WR_LOWER 8'h02
`define TCC_OP_RD_UPPER 8'hA1
`define TCC_OP_RD_LOWER 8'hA2
`define TCC_OP_WR_STATUS 8'h0C
`define TCC_OP_RD_STATUS 8'hAC
`define TCC_OP_RD_COUNT 8'hA0
`define TCC_OP_LD_COUNT 8'h41
// ************************************************************
// status byte fields
// ************************************************************
`define TCC_ST_DONE 7
`define TCC_ST_ONE 6
`define TCC_ST_BUSY 5
`define TCC_ST_HIF 4
`define TCC_ST_LOF 3
`define TCC_ST_PUP 2
`define TCC_ST_POLARITY 1
`define TCC_ST_SINGLE 0
// ************************************************************
// reset values of the store and timing
// ************************************************************
`define TCC_RST_UPPER 8'h00
`define TCC_RST_LOWER 8'h00
`define TCC_RST_CFG 5'h00
`define TCC_ESC_PULSES 5'h10
`define TCC_CLK_MHZ 250
`define TCC_NV_WRITE_MS 10
`define TCC_PWRDN_S 10
`define TCC_NV_WRITE_CYC (`TCC_NV_WRITE_MS * 1000 * `TCC_CLK_MHZ)
`define TCC_PWRDN_CYC (64'd`TCC_PWRDN_S * 64'd1000000 * 64'd`TCC_CLK_MHZ)
`endif

/* common/tcc_pkg.sv */
// types shared by the thermostat controller modules
`default_nettype none
package tcc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } tcc_state_t;
    // result handed over by the analog core at the end of a gate period
    typedef struct packed {
        logic [7:0] temp;
        logic [8:0] remain;
        logic [8:0] slope;
    } tcc_conv_t;
    // nonvolatile configuration bits
    typedef struct packed {
        logic hi_flag;
        logic lo_flag;
        logic pup_thermo;
        logic polarity;
        logic single;
    } tcc_cfg_t;
    typedef enum logic [1:0] {
        NV_UPPER = 2'b00,
        NV_LOWER = 2'b01,
        NV_STATUS = 2'b10
    } tcc_nvsel_t;
endpackage
`default_nettype wire

/* src/tcc_nvstore.sv */
// nonvolatile store for trip points, flags and selects with write-busy timing
`include "tcc_map.svh"
`default_nettype none
module tcc_nvstore #(
    parameter logic [31:0] WRITE_CYC = 32'(`TCC_NV_WRITE_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire tcc_pkg::tcc_nvsel_t sel_i,
    input wire logic [7:0] data_i,
    input wire logic hi_set_i,
    input wire logic lo_set_i,
    output logic [7:0] upper_o,
    output logic [7:0] lower_o,
    output tcc_pkg::tcc_cfg_t cfg_o,
    output logic busy_o
);
    logic [31:0] cnt_r;
    logic [7:0] data_r;
    tcc_pkg::tcc_nvsel_t sel_r;
    logic commit;

    assign commit = busy_o && (cnt_r == 32'h0000_0001);

    // ************************************************************
    // write window: writes while busy are dropped to avoid corruption
    // ************************************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            cnt_r <= 32'h0000_0000;
            data_r <= 8'h00;
            sel_r <= tcc_pkg::NV_UPPER;
        end else if (wr_i && !busy_o) begin // RULE20
            busy_o <= 1'b1;
            cnt_r <= WRITE_CYC;
            data_r <= data_i;
            sel_r <= sel_i;
        end else if (busy_o) begin
            cnt_r <= cnt_r - 32'h0000_0001;
            busy_o <= !commit;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            upper_o <= `TCC_RST_UPPER;
            lower_o <= `TCC_RST_LOWER;
        end else if (commit) begin // RULE19
            if (sel_r == tcc_pkg::NV_UPPER) begin
                upper_o <= data_r;
            end
            if (sel_r == tcc_pkg::NV_LOWER) begin
                lower_o <= data_r;
            end
        end
    end

    // flags: a hardware set in the commit cycle wins over the master's clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_o <= `TCC_RST_CFG;
        end else begin
            if (commit && sel_r == tcc_pkg::NV_STATUS) begin // RULE19
                cfg_o.pup_thermo <= data_r[`TCC_ST_PUP];
                cfg_o.polarity <= data_r[`TCC_ST_POLARITY];
                cfg_o.single <= data_r[`TCC_ST_SINGLE];
                cfg_o.hi_flag <= data_r[`TCC_ST_HIF] | hi_set_i; // RULE16
                cfg_o.lo_flag <= data_r[`TCC_ST_LOF] | lo_set_i; // RULE17
            end else begin
                cfg_o.hi_flag <= cfg_o.hi_flag | hi_set_i; // RULE16 RULE18
                cfg_o.lo_flag <= cfg_o.lo_flag | lo_set_i; // RULE17
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    busy_window_a: assert property ( // RULE20
        (wr_i && !busy_o) |=> busy_o [*8])
        else $error("store busy dropped too early");
endmodule // tcc_nvstore
`default_nettype wire

/* src/tcc_top.sv */
// conversion control, thermostat output and mode control of the temperature sensor
`include "tcc_map.svh"
`default_nettype none
module tcc_top #(
    parameter logic [31:0] NV_WRITE_CYC = 32'(`TCC_NV_WRITE_CYC),
    parameter logic [31:0] PWRDN_CYC = 32'(`TCC_PWRDN_CYC)
) (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic VDD_I,
    input wire logic DQ_I,
    output logic DQ_O,
    output logic DQ_OE_O,
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_OP_I,
    input wire logic [7:0] CMD_DATA_I,
    output logic RSP_VALID_O,
    output logic [8:0] RSP_DATA_O,
    output logic CONV_START_O,
    input wire logic CONV_DONE_I,
    input wire tcc_pkg::tcc_conv_t CONV_RES_I,
    output logic THERMO_MODE_O,
    output logic POWERED_DOWN_O
);
    // ************************************************************
    // declarations
    // ************************************************************
    tcc_pkg::tcc_state_t state_r;
    tcc_pkg::tcc_cfg_t cfg;
    logic [7:0] upper;
    logic [7:0] lower;
    logic nv_busy;

    logic [7:0] temp_r;
    logic [8:0] count_r;
    logic [8:0] slope_r;

    logic cont_r;
    logic done_r;
    logic act_r;
    logic thermo_r;

    logic vdd_prev_r;
    logic dq_prev_r;
    logic armed_r;
    logic [4:0] esc_cnt_r;
    logic esc_done_r;
    logic [31:0] pd_cnt_r;

    logic live;
    logic cmd;
    logic conv_end;
    logic hi_hit;
    logic lo_hit;
    logic nv_wr;
    tcc_pkg::tcc_nvsel_t nv_sel;

    // signed compare of two temperature bytes
    function automatic logic above(input logic [7:0] a, input logic [7:0] b);
        above = $signed(a) > $signed(b);
    endfunction

    function automatic logic is_op(input logic [7:0] op, input logic [7:0] code);
        is_op = (op == code);
    endfunction

    // the device answers commands only when powered and in communication mode
    assign live = VDD_I && !POWERED_DOWN_O;
    assign cmd = CMD_VALID_I && live && !thermo_r;
    assign conv_end = CONV_DONE_I && (state_r == tcc_pkg::ST_CONV);
    assign hi_hit = conv_end && above(CONV_RES_I.temp, upper); // RULE21
    assign lo_hit = conv_end && above(lower, CONV_RES_I.temp); // RULE21

    always_comb begin
        nv_wr = 1'b0;
        nv_sel = tcc_pkg::NV_UPPER;
        if (cmd) begin
            if (is_op(CMD_OP_I, `TCC_OP_WR_UPPER)) begin // RULE14
                nv_wr = 1'b1;
            end else if (is_op(CMD_OP_I, `TCC_OP_WR_LOWER)) begin
                nv_wr = 1'b1;
                nv_sel = tcc_pkg::NV_LOWER;
            end else if (is_op(CMD_OP_I, `TCC_OP_WR_STATUS)) begin
                nv_wr = 1'b1;
                nv_sel = tcc_pkg::NV_STATUS;
            end
        end
    end

    tcc_nvstore #(
        .WRITE_CYC(NV_WRITE_CYC)
    ) u_store (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .wr_i(nv_wr),
        .sel_i(nv_sel),
        .data_i(CMD_DATA_I),
        .hi_set_i(hi_hit),
        .lo_set_i(lo_hit),
        .upper_o(upper),
        .lower_o(lower),
        .cfg_o(cfg),
        .busy_o(nv_busy)
    );

    // ************************************************************
    // supply, escape sequence and power-down
    // ************************************************************
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            vdd_prev_r <= 1'b0;
            dq_prev_r <= 1'b1;
        end else begin
            vdd_prev_r <= VDD_I;
            dq_prev_r <= DQ_I;
        end
    end

    // pulses are only counted while the supply is held off with the line seen high first
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            armed_r <= 1'b0;
            esc_cnt_r <= 5'h00;
            esc_done_r <= 1'b0;
        end else if (VDD_I) begin
            armed_r <= 1'b0;
            esc_cnt_r <= 5'h00;
            if (!vdd_prev_r) begin
                esc_done_r <= 1'b0;
            end
        end else if (vdd_prev_r) begin
            armed_r <= DQ_I; // RULE2
            esc_cnt_r <= 5'h00;
            esc_done_r <= 1'b0;
        end else if (armed_r && dq_prev_r && !DQ_I && !esc_done_r) begin
            esc_cnt_r <= esc_cnt_r + 5'h01; // RULE2
            esc_done_r <= (esc_cnt_r + 5'h01) == `TCC_ESC_PULSES;
        end
    end

    // mode is picked at supply rise; the stored select is only read here, never written
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            thermo_r <= 1'b0;
        end else if (VDD_I && !vdd_prev_r) begin
            if (esc_done_r) begin
                thermo_r <= !thermo_r; // RULE3
            end else begin
                thermo_r <= cfg.pup_thermo; // RULE1
            end
        end
    end

    // power-down is left only by a fresh supply rise
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            pd_cnt_r <= 32'h0000_0000;
            POWERED_DOWN_O <= 1'b0;
        end else if (VDD_I) begin
            pd_cnt_r <= 32'h0000_0000;
            POWERED_DOWN_O <= 1'b0;
        end else if (DQ_I) begin
            pd_cnt_r <= 32'h0000_0000;
        end else if (pd_cnt_r >= PWRDN_CYC - 32'h0000_0001) begin
            POWERED_DOWN_O <= 1'b1; // RULE4
        end else begin
            pd_cnt_r <= pd_cnt_r + 32'h0000_0001;
        end
    end

    // ************************************************************
    // conversion control
    // ************************************************************
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= tcc_pkg::ST_IDLE;
            cont_r <= 1'b0;
            done_r <= 1'b0;
            CONV_START_O <= 1'b0;
        end else begin
            CONV_START_O <= 1'b0;
            if (!VDD_I || POWERED_DOWN_O) begin
                state_r <= tcc_pkg::ST_IDLE;
                cont_r <= 1'b0;
                done_r <= 1'b0;
            end else if (!vdd_prev_r) begin
                cont_r <= 1'b0;
                done_r <= 1'b0;
                if (esc_done_r ? !thermo_r : cfg.pup_thermo) begin
                    state_r <= tcc_pkg::ST_CONV; // RULE1
                    CONV_START_O <= 1'b1;
                end
            end else begin
                case (state_r)
                    tcc_pkg::ST_IDLE: begin
                        if (cmd && is_op(CMD_OP_I, `TCC_OP_START)) begin
                            state_r <= tcc_pkg::ST_CONV; // RULE8
                            CONV_START_O <= 1'b1;
                            cont_r <= !cfg.single; // RULE7
                            done_r <= 1'b0; // RULE10
                        end
                    end
                    tcc_pkg::ST_CONV: begin
                        if (cmd && is_op(CMD_OP_I, `TCC_OP_STOP) && cont_r) begin
                            state_r <= tcc_pkg::ST_IDLE; // RULE8
                            cont_r <= 1'b0;
                        end else if (conv_end) begin
                            if (cont_r || thermo_r) begin
                                CONV_START_O <= 1'b1; // RULE8
                            end else begin
                                state_r <= tcc_pkg::ST_IDLE; // RULE9
                                done_r <= 1'b1; // RULE10
                            end
                        end
                    end
                    default: begin
                        state_r <= tcc_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // result registers and the counter readback path
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            temp_r <= 8'h00;
            count_r <= 9'h000;
            slope_r <= 9'h000;
        end else if (conv_end) begin
            temp_r <= CONV_RES_I.temp; // RULE5
            count_r <= CONV_RES_I.remain; // RULE11
            slope_r <= CONV_RES_I.slope;
        end else if (cmd && is_op(CMD_OP_I, `TCC_OP_LD_COUNT)) begin
            count_r <= slope_r; // RULE12
        end
    end

    // ************************************************************
    // thermostat output with hysteresis
    // ************************************************************
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            act_r <= 1'b0;
        end else if (hi_hit) begin
            act_r <= 1'b1; // RULE13
        end else if (lo_hit) begin
            act_r <= 1'b0; // RULE13
        end
    end

    // open drain: in thermostat mode with the supply up, the pin is pulled low whenever the wanted level is low
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            DQ_O <= 1'b0;
            DQ_OE_O <= 1'b0;
            THERMO_MODE_O <= 1'b0;
        end else begin
            DQ_O <= 1'b0;
            DQ_OE_O <= thermo_r && live && (act_r ^ cfg.polarity); // RULE15
            THERMO_MODE_O <= thermo_r;
        end
    end

    // ************************************************************
    // command answers
    // ************************************************************
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            RSP_VALID_O <= 1'b0;
            RSP_DATA_O <= 9'h000;
        end else begin
            RSP_VALID_O <= 1'b0;
            if (cmd) begin
                RSP_VALID_O <= 1'b1;
                case (CMD_OP_I)
                    `TCC_OP_RD_TEMP: RSP_DATA_O <= {1'b0, temp_r}; // RULE6
                    `TCC_OP_RD_UPPER: RSP_DATA_O <= {1'b0, upper};
                    `TCC_OP_RD_LOWER: RSP_DATA_O <= {1'b0, lower};
                    `TCC_OP_RD_COUNT: RSP_DATA_O <= count_r; // RULE11
                    // done only reports one-shot conversions; continuous mode reads 0
                    `TCC_OP_RD_STATUS: RSP_DATA_O <= {1'b0, done_r & cfg.single, 1'b1, nv_busy,
                        cfg.hi_flag, cfg.lo_flag, cfg.pup_thermo, cfg.polarity, cfg.single};
                    default: RSP_VALID_O <= 1'b0;
                endcase
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    sequence one_shot_end;
        conv_end && !cont_r && !thermo_r && VDD_I && vdd_prev_r && !POWERED_DOWN_O;
    endsequence

    done_cont_low_a: assert property ((cont_r || thermo_r) |-> !done_r) // RULE10
        else $error("done flag high in continuous conversion");

    one_shot_stop_a: assert property ( // RULE9
        one_shot_end |=> (state_r == tcc_pkg::ST_IDLE) && done_r && !CONV_START_O)
        else $error("one-shot did not stop with done");

    start_conv_a: assert property ( // RULE8
        (cmd && state_r == tcc_pkg::ST_IDLE && vdd_prev_r && is_op(CMD_OP_I, `TCC_OP_START))
        |=> CONV_START_O && state_r == tcc_pkg::ST_CONV)
        else $error("start opcode did not start a conversion");

    high_flag_a: assert property (hi_hit |=> cfg.hi_flag) // RULE16
        else $error("high flag not set");

    low_flag_a: assert property (lo_hit |=> cfg.lo_flag) // RULE17
        else $error("low flag not set");

    thermo_hyst_a: assert property ( // RULE13
        (act_r && !lo_hit) |=> act_r)
        else $error("thermostat output dropped without low crossing");

    polarity_drive_a: assert property ( // RULE15
        (thermo_r && live && (act_r ^ cfg.polarity)) |=> DQ_OE_O)
        else $error("thermostat level not driven");

    temp_hidden_a: assert property ( // RULE6
        (CMD_VALID_I && thermo_r) |=> !RSP_VALID_O)
        else $error("answer given in thermostat mode");

    load_count_a: assert property ( // RULE12
        (cmd && !conv_end && is_op(CMD_OP_I, `TCC_OP_LD_COUNT)) |=> count_r == $past(slope_r))
        else $error("slope not copied to counter");

    escape_toggle_a: assert property ( // RULE3
        (VDD_I && !vdd_prev_r && esc_done_r) |=> thermo_r != $past(thermo_r))
        else $error("escape did not switch mode");

    pwrdn_entry_a: assert property ( // RULE4
        (!VDD_I && !DQ_I && pd_cnt_r >= PWRDN_CYC - 32'h0000_0001) |=> POWERED_DOWN_O)
        else $error("power-down not entered");

    temp_load_a: assert property (conv_end |=> temp_r == $past(CONV_RES_I.temp)) // RULE5
        else $error("temperature not loaded");
endmodule // tcc_top
`default_nettype wire

/* testbench/tcc_core_model.sv */
// behavioural analog core that answers each gate-period start after a set latency
`default_nettype none
module tcc_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] lat_i,
    input wire logic [7:0] temp_i,
    input wire logic [8:0] remain_i,
    input wire logic [8:0] slope_i,
    output logic done_o,
    output tcc_pkg::tcc_conv_t res_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_r;
    logic run_r;
    // ************************************************************
    // gate period
    // ************************************************************
    // result lines toggle outside the done pulse, so a late sample is caught
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            run_r <= 1'b0;
            done_o <= 1'b0;
            res_o <= '0;
        end else begin
            done_o <= 1'b0;
            res_o <= ~res_o;
            if (start_i) begin
                cnt_r <= lat_i;
                run_r <= 1'b1;
            end else if (run_r && cnt_r <= 8'h01) begin
                run_r <= 1'b0;
                done_o <= 1'b1;
                res_o <= {temp_i, remain_i, slope_i};
            end else if (run_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule // tcc_core_model
`default_nettype wire

/* testbench/thermostat_conversion_control_tb_top.sv */
// self-checking bench of the thermostat conversion controller
`include "tcc_map.svh"
`default_nettype none
module thermostat_conversion_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] NV_CYC = 32'h0000_0014;
    localparam logic [31:0] PD_CYC = 32'h0000_0032;
    logic mclk, rst, vdd, dq_m, dq_i, dq_o, dq_oe, cmd_valid, rsp_valid, conv_start, conv_done;
    logic thermo, pwrdn, last_v, last_cs;
    logic [7:0] cmd_op, cmd_data, m_lat, m_temp;
    logic [8:0] rsp_data, m_remain, m_slope, last_r;
    tcc_pkg::tcc_conv_t conv_res;
    int fails, checks_done, starts, s0;
    // open-drain line with pull-up: low whenever either side pulls
    assign dq_i = dq_m & ~dq_oe;
    tcc_top #(.NV_WRITE_CYC(NV_CYC), .PWRDN_CYC(PD_CYC)) dut (
        .MCLK_I(mclk), .RST_I(rst), .VDD_I(vdd), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_O(dq_oe),
        .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op), .CMD_DATA_I(cmd_data),
        .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data), .CONV_START_O(conv_start),
        .CONV_DONE_I(conv_done), .CONV_RES_I(conv_res), .THERMO_MODE_O(thermo),
        .POWERED_DOWN_O(pwrdn));
    tcc_core_model core (.clk_i(mclk), .rst_i(rst), .start_i(conv_start), .lat_i(m_lat),
        .temp_i(m_temp), .remain_i(m_remain), .slope_i(m_slope), .done_o(conv_done),
        .res_o(conv_res));
    always @(posedge mclk) if (conv_start === 1'b1) starts++;
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // a spare cycle at the end keeps the strobe from being re-raised in the same step
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = d;
        cyc(1);
        cmd_valid = 1'b0;
        last_v = rsp_valid;
        last_r = rsp_data;
        last_cs = conv_start;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] op, input logic [8:0] exp, input string m);
        cmd(op, 8'h00);
        chk(9'(last_v), 9'h001, m);
        chk(last_r, exp, m);
    endtask
    task automatic nv_wait;
        int n;
        n = 0;
        cmd(`TCC_OP_RD_STATUS, 8'h00);
        while (last_r[`TCC_ST_BUSY] !== 1'b0 && n < 100) begin
            cmd(`TCC_OP_RD_STATUS, 8'h00);
            n++;
        end
        chk(9'(n < 100), 9'h001, "store busy");
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        cmd(op, d);
        nv_wait();
    endtask
    // supply drop with the line held high, optionally with sixteen low pulses
    task automatic power(input logic esc);
        vdd = 1'b0;
        dq_m = 1'b1;
        cyc(2);
        if (esc) repeat (16) begin
            dq_m = 1'b0;
            cyc(1);
            dq_m = 1'b1;
            cyc(1);
        end
        vdd = 1'b1;
        cyc(2);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        chk(9'(thermo), 9'h000, "mode after reset");
        rd(`TCC_OP_RD_STATUS, 9'h040, "status reset");
        rd(`TCC_OP_RD_UPPER, 9'h000, "upper reset");
        cmd(8'h55, 8'h00);
        chk(9'(last_v), 9'h000, "unknown opcode answered");
        $display("test reset done");
    endtask
    task automatic t_trip;
        cmd(`TCC_OP_WR_UPPER, 8'h7D);
        rd(`TCC_OP_RD_STATUS, 9'h060, "busy");
        cmd(`TCC_OP_WR_LOWER, 8'hC9);
        nv_wait();
        rd(`TCC_OP_RD_UPPER, 9'h07D, "upper");
        rd(`TCC_OP_RD_LOWER, 9'h000, "write while busy");
        wr(`TCC_OP_WR_LOWER, 8'hC9);
        rd(`TCC_OP_RD_LOWER, 9'h0C9, "lower");
        wr(`TCC_OP_WR_UPPER, 8'h19);
        wr(`TCC_OP_WR_LOWER, 8'hE7);
        $display("test trip points done");
    endtask
    task automatic t_single;
        wr(`TCC_OP_WR_STATUS, 8'h01);
        m_temp = 8'h7D;
        m_remain = 9'h1A5;
        m_slope = 9'h0F3;
        m_lat = 8'h06;
        s0 = starts;
        cmd(`TCC_OP_START, 8'h00);
        chk(9'(last_cs), 9'h001, "start pulse");
        rd(`TCC_OP_RD_STATUS, 9'h041, "done while busy");
        cyc(12);
        rd(`TCC_OP_RD_STATUS, 9'h0D1, "done and high flag");
        rd(`TCC_OP_RD_TEMP, 9'h07D, "temperature");
        chk(9'(starts - s0), 9'h001, "one conversion");
        rd(`TCC_OP_RD_COUNT, 9'h1A5, "remaining count");
        cmd(`TCC_OP_LD_COUNT, 8'h00);
        rd(`TCC_OP_RD_COUNT, 9'h0F3, "slope count");
        $display("test one-shot done");
    endtask
    task automatic t_cont;
        wr(`TCC_OP_WR_STATUS, 8'h00);
        rd(`TCC_OP_RD_STATUS, 9'h040, "flags cleared");
        m_temp = 8'hE2;
        m_lat = 8'h03;
        s0 = starts;
        cmd(`TCC_OP_START, 8'h00);
        cyc(20);
        chk(9'(starts - s0 >= 3), 9'h001, "repeated starts");
        rd(`TCC_OP_RD_STATUS, 9'h048, "low flag");
        m_temp = 8'h1E;
        cyc(10);
        rd(`TCC_OP_RD_STATUS, 9'h058, "both flags kept");
        cmd(`TCC_OP_STOP, 8'h00);
        cyc(8);
        s0 = starts;
        cyc(20);
        chk(9'(starts - s0), 9'h000, "stopped");
        rd(`TCC_OP_RD_TEMP, 9'h01E, "last temperature");
        $display("test continuous done");
    endtask
    task automatic t_thermo;
        wr(`TCC_OP_WR_STATUS, 8'h07);
        m_lat = 8'h04;
        power(1'b0);
        chk(9'(thermo), 9'h001, "thermostat start");
        s0 = starts;
        cyc(12);
        chk(9'(starts - s0 >= 2), 9'h001, "continuous in thermostat");
        chk(9'({dq_o, dq_oe}), 9'h000, "hot active high");
        m_temp = 8'h00;
        cyc(12);
        chk(9'(dq_oe), 9'h000, "hysteresis hold");
        m_temp = 8'hE2;
        cyc(12);
        chk(9'(dq_oe), 9'h001, "cold inactive");
        m_temp = 8'h00;
        cyc(12);
        chk(9'(dq_oe), 9'h001, "hysteresis low");
        cmd(`TCC_OP_RD_TEMP, 8'h00);
        chk(9'(last_v), 9'h000, "read in thermostat");
        m_temp = 8'h1E;
        cyc(12);
        power(1'b1);
        chk(9'(thermo), 9'h000, "escape");
        cmd(`TCC_OP_RD_STATUS, 8'h00);
        chk(last_r & 9'h07F, 9'h05F, "select kept");
        wr(`TCC_OP_WR_STATUS, 8'h04);
        power(1'b0);
        cyc(12);
        chk(9'(dq_oe), 9'h001, "hot active low");
        m_temp = 8'hE2;
        cyc(12);
        chk(9'(dq_oe), 9'h000, "cold active low");
        power(1'b1);
        chk(9'(thermo), 9'h000, "second escape");
        power(1'b1);
        chk(9'(thermo), 9'h001, "escape back");
        $display("test thermostat done");
    endtask
    task automatic t_pwrdn;
        vdd = 1'b0;
        dq_m = 1'b0;
        cyc(40);
        chk(9'(pwrdn), 9'h000, "early power-down");
        cyc(20);
        chk(9'(pwrdn), 9'h001, "power-down");
        vdd = 1'b1;
        dq_m = 1'b1;
        cyc(2);
        chk(9'(pwrdn), 9'h000, "wake");
        $display("test power-down done");
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        {rst, vdd, dq_m, cmd_valid, cmd_op, cmd_data} = {1'b1, 1'b0, 1'b1, 1'b0, 16'h0000};
        {m_lat, m_temp, m_remain, m_slope} = {8'h02, 8'h00, 18'h0_0000};
        cyc(3);
        rst = 1'b0;
        cyc(1);
        power(1'b0);
        t_reset();
        t_trip();
        t_single();
        t_cont();
        t_thermo();
        t_pwrdn();
        conclude();
    end
endmodule // thermostat_conversion_control_tb_top
`default_nettype wire
